// ---- lel_limits.sv ----
// Reduced-profile encapsulation limit checker for packets leaving the encapsulator.
`timescale 1ns/1ns
module lel_limits
    import lel_pkg::*;
(
    input  wire logic                   CORE_CLK,
    input  wire logic                   RST_N,
    input  wire logic                   CE,
    input  wire logic                   FRAME_TICK,
    input  wire logic                   HIGH_EFFICIENCY_PHYSICAL_MODE,
    input  wire logic                   PKT_VALID,
    input  wire logic                   PKT_START,
    input  wire logic                   PKT_END,
    input  wire logic [LEL_TAG_W-1:0]   PKT_FRAGMENT_TAG,
    input  wire logic [1:0]             PKT_LABEL_TYPE_FIELD,
    input  wire logic [LEL_LABEL_W-1:0] PKT_LABEL,
    input  wire logic [15:0]            PDU_LEN,
    input  wire logic [15:0]            PKT_LEN,
    output logic                        PKT_READY,
    output logic                        PKT_PASS,
    output logic                        PKT_DROP,
    output logic [2:0]                  DROP_CAUSE,
    output logic [15:0]                 OUT_PKT_LEN,
    output logic                        ABANDON,
    output logic [LEL_TAG_W-1:0]        ABANDON_TAG
);

    ////////////////////////////////////////////////////////////////////////////////
    // Tracking table.

    logic [LEL_NUM_SLOTS-1:0] alloc_v, frag_v, drop_v;
    logic [LEL_NUM_SLOTS-1:0] s_valid, s_expired, s_match, s_hit;
    lel_tag_t                 s_tag   [LEL_NUM_SLOTS];
    logic [2:0]               s_count [LEL_NUM_SLOTS];
    lel_dest_t                dest_key;

    lel_slot_if slot_bus [LEL_NUM_SLOTS] ();

    // Destination key: broadcast and reuse ignore the label, a short label keeps 3 bytes.
    always_comb begin
        unique case (PKT_LABEL_TYPE_FIELD)
            LEL_LT_SIX_BYTE:   dest_key = {PKT_LABEL_TYPE_FIELD, PKT_LABEL};
            LEL_LT_THREE_BYTE: dest_key = {PKT_LABEL_TYPE_FIELD, 24'h000000, PKT_LABEL[23:0]};
            LEL_LT_BROADCAST:  dest_key = {PKT_LABEL_TYPE_FIELD, 48'h000000000000};
            LEL_LT_REUSE:      dest_key = {PKT_LABEL_TYPE_FIELD, 48'h000000000000};
        endcase
    end

    // Slots and their match terms; a destination counts per label, as tags are per destination.
    for (genvar g = 0; g < LEL_NUM_SLOTS; g++) begin : g_slot
        lel_slot u_slot (
            .clk        (CORE_CLK),
            .rst_n      (RST_N),
            .ce         (CE),
            .frame_tick (FRAME_TICK),
            .bus        (slot_bus[g])
        );
        assign slot_bus[g].alloc    = alloc_v[g];
        assign slot_bus[g].frag     = frag_v[g];
        assign slot_bus[g].drop     = drop_v[g];
        assign slot_bus[g].new_tag  = PKT_FRAGMENT_TAG;
        assign slot_bus[g].new_dest = dest_key;
        assign s_valid[g]   = slot_bus[g].valid;
        assign s_expired[g] = slot_bus[g].expired;
        assign s_tag[g]     = slot_bus[g].tag;
        assign s_count[g]   = slot_bus[g].count;
        assign s_hit[g]     = slot_bus[g].valid && (slot_bus[g].dest == dest_key);
        assign s_match[g]   = s_hit[g] && (slot_bus[g].tag == PKT_FRAGMENT_TAG);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Table searches.

    logic [3:0]           open_cnt;
    logic [LEL_IDX_W-1:0] free_idx, match_idx, exp_idx;
    logic                 free_any, match_any, exp_any;
    logic                 size_bad;

    // Lowest free, matching and expired slots, plus open tags for this destination.
    always_comb begin
        open_cnt  = 4'h0;
        free_idx  = '0;
        match_idx = '0;
        exp_idx   = '0;
        for (int i = LEL_NUM_SLOTS - 1; i >= 0; i--) begin
            open_cnt = open_cnt + {3'h0, s_hit[i]};
            if (!s_valid[i]) begin
                free_idx = LEL_IDX_W'(i);
            end
            if (s_match[i]) begin
                match_idx = LEL_IDX_W'(i);
            end
            if (s_expired[i]) begin
                exp_idx = LEL_IDX_W'(i);
            end
        end
    end

    assign free_any  = !(&s_valid);
    assign match_any = |s_match;
    assign exp_any   = |s_expired;
    assign size_bad  = (PDU_LEN > LEL_MAX_PDU_BYTES) || (PKT_LEN > LEL_MAX_PKT_BYTES);

    // No buffer here: every packet is judged in the cycle it is offered.
    assign PKT_READY = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and slot control.

    lel_cause_t cause;
    logic       pkt_abandon;
    logic       pass_nxt, drop_nxt, aband_nxt;
    lel_tag_t   aband_tag_nxt;

    // One packet per cycle; its own abandon takes the report, else one expired slot is swept.
    always_comb begin
        cause       = LEL_CAUSE_NONE;
        pkt_abandon = 1'b0;
        alloc_v     = '0;
        frag_v      = '0;
        drop_v      = '0;
        if (PKT_VALID) begin
            if (HIGH_EFFICIENCY_PHYSICAL_MODE && !(PKT_START && PKT_END)) begin
                cause = LEL_CAUSE_HEM;
                if (match_any) begin
                    pkt_abandon = 1'b1;
                end
            end else if (size_bad) begin
                cause = LEL_CAUSE_SIZE;
                if (!PKT_START && match_any) begin
                    pkt_abandon = 1'b1;
                end
            end else if (PKT_START && !PKT_END) begin
                if (match_any || !free_any) begin
                    cause = LEL_CAUSE_NOCTX;
                end else if (open_cnt >= LEL_MAX_OPEN_TAGS) begin
                    cause = LEL_CAUSE_TAGS;
                end else begin
                    alloc_v[free_idx] = 1'b1;
                end
            end else if (!PKT_START) begin
                if (!match_any) begin
                    cause = LEL_CAUSE_NOCTX;
                end else if (s_expired[match_idx]) begin
                    cause       = LEL_CAUSE_DEADLINE;
                    pkt_abandon = 1'b1;
                end else if (s_count[match_idx] >= LEL_MAX_FRAGS) begin
                    cause       = LEL_CAUSE_COUNT;
                    pkt_abandon = 1'b1;
                end else if (PKT_END) begin
                    drop_v[match_idx] = 1'b1;
                end else begin
                    frag_v[match_idx] = 1'b1;
                end
            end
        end
        if (pkt_abandon) begin
            drop_v[match_idx] = 1'b1;
        end
        aband_nxt     = pkt_abandon;
        aband_tag_nxt = s_tag[match_idx];
        if (!pkt_abandon && exp_any && !(PKT_VALID && match_any && (exp_idx == match_idx))) begin
            drop_v[exp_idx] = 1'b1;
            aband_nxt       = 1'b1;
            aband_tag_nxt   = s_tag[exp_idx];
        end
        pass_nxt = PKT_VALID && (cause == LEL_CAUSE_NONE);
        drop_nxt = PKT_VALID && (cause != LEL_CAUSE_NONE);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output registers.

    logic                pass_r, drop_r, aband_r;
    lel_cause_t          cause_r;
    lel_tag_t            aband_tag_r;
    logic [15:0]         out_len_r, out_pdu_r;

    // Passed lengths are copied untouched, so any lower slicing cannot show here.
    always_ff @(posedge CORE_CLK) begin
        if (!RST_N) begin
            pass_r      <= 1'b0;
            drop_r      <= 1'b0;
            cause_r     <= LEL_CAUSE_NONE;
            aband_r     <= 1'b0;
            aband_tag_r <= '0;
            out_len_r   <= 16'h0000;
            out_pdu_r   <= 16'h0000;
        end else if (CE) begin
            pass_r      <= pass_nxt;
            drop_r      <= drop_nxt;
            cause_r     <= cause;
            aband_r     <= aband_nxt;
            aband_tag_r <= aband_tag_nxt;
            out_len_r   <= PKT_LEN;
            out_pdu_r   <= PDU_LEN;
        end
    end

    assign PKT_PASS    = pass_r;
    assign PKT_DROP    = drop_r;
    assign DROP_CAUSE  = cause_r;
    assign OUT_PKT_LEN = out_len_r;
    assign ABANDON     = aband_r;
    assign ABANDON_TAG = aband_tag_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_pdu_size_cap: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        PKT_PASS |-> (out_pdu_r <= LEL_MAX_PDU_BYTES))
        else $error("Passed data unit exceeds the size cap.");

    a_pkt_size_cap: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && PKT_VALID && (PKT_LEN > LEL_MAX_PKT_BYTES)
        |=> PKT_DROP && !PKT_PASS && (OUT_PKT_LEN > LEL_MAX_PKT_BYTES))
        else $error("Oversized packet was not dropped.");

    a_open_tag_cap: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && PKT_VALID && PKT_START && !PKT_END && !HIGH_EFFICIENCY_PHYSICAL_MODE
        && !size_bad && !match_any && free_any && (open_cnt >= LEL_MAX_OPEN_TAGS)
        |=> PKT_DROP && (DROP_CAUSE == LEL_CAUSE_TAGS))
        else $error("Fifth open tag for a destination was accepted.");

    a_frag_count_cap: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && PKT_VALID && !PKT_START && !HIGH_EFFICIENCY_PHYSICAL_MODE && !size_bad
        && match_any && !s_expired[match_idx] && (s_count[match_idx] == LEL_MAX_FRAGS)
        |=> PKT_DROP && (DROP_CAUSE == LEL_CAUSE_COUNT) && ABANDON)
        else $error("Seventh fragment was not refused.");

    // A second expired slot may be swept in the very next cycle, so only this cycle is checked.
    a_late_frag_drop: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && PKT_VALID && !PKT_START && !HIGH_EFFICIENCY_PHYSICAL_MODE && !size_bad
        && match_any && s_expired[match_idx]
        |=> PKT_DROP && (DROP_CAUSE == LEL_CAUSE_DEADLINE) && ABANDON
        && (ABANDON_TAG == $past(PKT_FRAGMENT_TAG)))
        else $error("Fragment past the frame deadline was passed.");

    a_hem_no_frag: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        CE && PKT_VALID && HIGH_EFFICIENCY_PHYSICAL_MODE && !(PKT_START && PKT_END)
        |=> PKT_DROP && (DROP_CAUSE == LEL_CAUSE_HEM))
        else $error("Fragment passed in high-efficiency mode.");

    a_pass_unchanged: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        $past(CE) && PKT_PASS |-> (OUT_PKT_LEN == $past(PKT_LEN)) && $past(PKT_VALID))
        else $error("Passed packet length differs from the offered one.");

    a_drop_has_cause: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
        PKT_DROP |-> (DROP_CAUSE != LEL_CAUSE_NONE) && !PKT_PASS)
        else $error("Drop reported without a cause.");

endmodule : lel_limits

// ---- lel_pkg.sv ----
// Shared constants and types for the reduced-profile encapsulation limit checker.
package lel_pkg;

    // Size limits in bytes.
    localparam logic [15:0] LEL_MAX_PDU_BYTES = 16'd1800;
    localparam logic [15:0] LEL_MAX_PKT_BYTES = 16'd1800;

    // Fragmentation limits.
    localparam logic [3:0]  LEL_MAX_OPEN_TAGS = 4'h4;
    localparam logic [2:0]  LEL_MAX_FRAGS     = 3'h6;
    localparam logic [6:0]  LEL_MAX_FRAMES    = 7'h40;

    // Tracking table depth and field widths.
    localparam int          LEL_NUM_SLOTS     = 8;
    localparam int          LEL_IDX_W         = 3;
    localparam int          LEL_TAG_W         = 8;
    localparam int          LEL_LABEL_W       = 48;
    localparam int          LEL_DEST_W        = 50;

    // Label type field codes.
    localparam logic [1:0]  LEL_LT_SIX_BYTE   = 2'h0;
    localparam logic [1:0]  LEL_LT_THREE_BYTE = 2'h1;
    localparam logic [1:0]  LEL_LT_BROADCAST  = 2'h2;
    localparam logic [1:0]  LEL_LT_REUSE      = 2'h3;

    typedef logic [LEL_TAG_W-1:0]  lel_tag_t;
    typedef logic [LEL_DEST_W-1:0] lel_dest_t;

    // Drop causes reported with each refused packet.
    typedef enum logic [2:0] {
        LEL_CAUSE_NONE     = 3'b000,
        LEL_CAUSE_SIZE     = 3'b001,
        LEL_CAUSE_TAGS     = 3'b010,
        LEL_CAUSE_COUNT    = 3'b011,
        LEL_CAUSE_DEADLINE = 3'b100,
        LEL_CAUSE_HEM      = 3'b101,
        LEL_CAUSE_NOCTX    = 3'b110
    } lel_cause_t;

endpackage : lel_pkg

// ---- lel_slot_if.sv ----
// Control and status bundle between the checker and one fragment tracking slot.
`timescale 1ns/1ns
interface lel_slot_if;
    import lel_pkg::*;
    logic      alloc;
    logic      frag;
    logic      drop;
    lel_tag_t  new_tag;
    lel_dest_t new_dest;
    logic      valid;
    lel_tag_t  tag;
    lel_dest_t dest;
    logic [2:0] count;
    logic      expired;

    modport owner (output alloc, frag, drop, new_tag, new_dest,
                   input  valid, tag, dest, count, expired);
    modport slot  (input  alloc, frag, drop, new_tag, new_dest,
                   output valid, tag, dest, count, expired);
endinterface : lel_slot_if

// ---- lel_slot.sv ----
// One open fragment tag: its destination, fragment count and frame age.
`timescale 1ns/1ns
module lel_slot
    import lel_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic frame_tick,
    lel_slot_if.slot  bus
);

    logic       valid_r, valid_nxt;
    lel_tag_t   tag_r, tag_nxt;
    lel_dest_t  dest_r, dest_nxt;
    logic [2:0] count_r, count_nxt;
    logic [6:0] age_r, age_nxt;

    // Release wins over allocation; the age stops at the deadline so it cannot wrap.
    always_comb begin
        valid_nxt = valid_r;
        tag_nxt   = tag_r;
        dest_nxt  = dest_r;
        count_nxt = count_r;
        age_nxt   = age_r;
        if (bus.drop) begin
            valid_nxt = 1'b0;
        end else if (bus.alloc) begin
            valid_nxt = 1'b1;
            tag_nxt   = bus.new_tag;
            dest_nxt  = bus.new_dest;
            count_nxt = 3'h1;
            age_nxt   = 7'h00;
        end else begin
            if (bus.frag) begin
                count_nxt = count_r + 3'h1;
            end
            if (frame_tick && valid_r && (age_r != LEL_MAX_FRAMES)) begin
                age_nxt = age_r + 7'h01;
            end
        end
    end

    // State register, frozen while the clock enable is low.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            valid_r <= 1'b0;
            tag_r   <= '0;
            dest_r  <= '0;
            count_r <= 3'h0;
            age_r   <= 7'h00;
        end else if (ce) begin
            valid_r <= valid_nxt;
            tag_r   <= tag_nxt;
            dest_r  <= dest_nxt;
            count_r <= count_nxt;
            age_r   <= age_nxt;
        end
    end

    assign bus.valid   = valid_r;
    assign bus.tag     = tag_r;
    assign bus.dest    = dest_r;
    assign bus.count   = count_r;
    assign bus.expired = valid_r && (age_r == LEL_MAX_FRAMES);

    a_age_bounded: assert property (@(posedge clk) disable iff (!rst_n)
        valid_r && frame_tick && ce && (age_r == LEL_MAX_FRAMES)
        |=> (age_r == LEL_MAX_FRAMES) || !valid_r)
        else $error("Fragment age ran past the frame deadline.");

endmodule : lel_slot

// ---- lel_rx_model.sv ----
// Far-side receiver model that counts passed packets and their bytes and tallies abandoned units.
`timescale 1ns/1ns
module lel_rx_model
    import lel_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        pass,
    input  wire logic [15:0] len,
    input  wire logic        abandon,
    output logic      [15:0] n_pass,
    output logic      [15:0] rx_bytes,
    output logic      [15:0] n_abandon
);
    ////////////////////////////////////////////////////////////////////////////////
    // Only counters are kept, not the single reassembly context that is the least a receiver must offer.
    // Packets arrive one per cycle at most, so taking each in turn never loses one.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            n_pass    <= 16'h0;
            rx_bytes  <= 16'h0;
            n_abandon <= 16'h0;
        end else begin
            if (pass) begin
                n_pass   <= n_pass + 16'h1;
                rx_bytes <= rx_bytes + len;
            end
            if (abandon) begin
                n_abandon <= n_abandon + 16'h1;
            end
        end
    end
endmodule : lel_rx_model

// ---- lite_encapsulation_limits_tb_top.sv ----
// Self-checking testbench for the reduced-profile encapsulation limit checker.
`timescale 1ns/1ns
module lite_encapsulation_limits_tb_top
    import lel_pkg::*;
;
    logic        clk, rst_n, ce, tick, high_efficiency_physical_mode, vld, st, en;
    logic [7:0]  tag;
    logic [1:0]  lt;
    logic [47:0] lbl;
    logic [15:0] pdu, pkt, out_len, m_pass, m_bytes, m_ab;
    logic        rdy, pass, drop, ab;
    logic [2:0]  cause;
    logic [7:0]  ab_tag;
    int          error_cnt, n_compared, exp_pass, exp_bytes;

    lel_limits i_dut (.CORE_CLK(clk), .RST_N(rst_n), .CE(ce), .FRAME_TICK(tick),
        .HIGH_EFFICIENCY_PHYSICAL_MODE(high_efficiency_physical_mode), .PKT_VALID(vld), .PKT_START(st), .PKT_END(en),
        .PKT_FRAGMENT_TAG(tag), .PKT_LABEL_TYPE_FIELD(lt), .PKT_LABEL(lbl), .PDU_LEN(pdu),
        .PKT_LEN(pkt), .PKT_READY(rdy), .PKT_PASS(pass), .PKT_DROP(drop), .DROP_CAUSE(cause),
        .OUT_PKT_LEN(out_len), .ABANDON(ab), .ABANDON_TAG(ab_tag));

    lel_rx_model i_rx (.clk(clk), .rst_n(rst_n), .pass(pass), .len(out_len), .abandon(ab),
        .n_pass(m_pass), .rx_bytes(m_bytes), .n_abandon(m_ab));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 4 ns period.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Compares one response triple of pass, drop and cause.
    task automatic chk_resp(input logic [4:0] got, input logic [4:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t resp got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_resp

    // Compares one data value.
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t value got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_val

    // Expected response to a complete packet: only the size limits can refuse it.
    function automatic logic [4:0] exp_whole(input logic [15:0] p, input logic [15:0] k);
        return (p > 16'd1800 || k > 16'd1800) ? 5'h09 : 5'h10;
    endfunction : exp_whole

    // Offers one packet, then checks the answer one cycle later.
    // A frame pulse raised at the edge before the call ends where the packet starts.
    task automatic send(input logic s, input logic e, input logic [7:0] t, input logic [1:0] l,
                        input logic [15:0] p, input logic [15:0] k, input logic [4:0] exp,
                        input logic xab);
        @(posedge clk);
        vld <= 1'b1;
        tick <= 1'b0;
        st  <= s;
        en  <= e;
        tag <= t;
        lt  <= l;
        pdu <= p;
        pkt <= k;
        @(posedge clk);
        vld <= 1'b0;
        #1;
        chk_resp({pass, drop, cause}, exp);
        if (exp[4]) begin
            exp_pass++;
            exp_bytes += k;
            chk_val(out_len, k);
        end
        chk_val({15'h0, ab}, {15'h0, xab});
        if (xab) begin
            chk_val({8'h0, ab_tag}, {8'h0, t});
        end
    endtask : send

    // One frame pulse.
    task automatic frame();
        @(posedge clk);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
    endtask : frame

    // Prints the counts and the verdict, then ends the run.
    task automatic print_verdict();
        $display("errors=%0d compared=%0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: corner cases first, then random complete packets.
    initial begin
        int i;
        logic [15:0] rp, rk;
        {rst_n, ce, tick, high_efficiency_physical_mode, vld, st, en, tag, lt, lbl, pdu, pkt} = '0;
        error_cnt = 0;
        n_compared = 0;
        exp_pass = 0;
        exp_bytes = 0;
        void'($urandom(21464));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        ce    <= 1'b1;
        lbl   <= 48'ha1b2c3d4e5f6;
        chk_val({15'h0, rdy}, 16'h1);
        // Size boundaries on both lengths.
        send(1, 1, 8'h01, 2'h0, 16'd1800, 16'd1800, 5'h10, 0);
        send(1, 1, 8'h01, 2'h0, 16'd1801, 16'd100, 5'h09, 0);
        send(1, 1, 8'h01, 2'h0, 16'd1000, 16'd1801, 5'h09, 0);
        // With the clock enable low an oversized packet must leave no answer at all.
        @(posedge clk);
        ce <= 1'b0;
        send(1, 1, 8'h01, 2'h0, 16'd1801, 16'd100, 5'h00, 0);
        @(posedge clk);
        ce <= 1'b1;
        // Four open tags per destination, a fifth refused, another destination allowed.
        for (i = 1; i <= 4; i++) send(1, 0, i[7:0], 2'h2, 16'd900, 16'd300, 5'h10, 0);
        send(1, 0, 8'h05, 2'h2, 16'd900, 16'd300, 5'h0a, 0);
        send(1, 0, 8'h01, 2'h2, 16'd900, 16'd300, 5'h0e, 0);
        send(1, 0, 8'h06, 2'h1, 16'd900, 16'd300, 5'h10, 0);
        for (i = 1; i <= 4; i++) send(0, 1, i[7:0], 2'h2, 16'd900, 16'd600, 5'h10, 0);
        send(0, 1, 8'h06, 2'h1, 16'd900, 16'd600, 5'h10, 0);
        // Six fragments pass; a seventh is refused and the unit abandoned.
        send(1, 0, 8'h0a, 2'h0, 16'd1800, 16'd300, 5'h10, 0);
        for (i = 0; i < 4; i++) send(0, 0, 8'h0a, 2'h0, 16'd1800, 16'd300, 5'h10, 0);
        send(0, 1, 8'h0a, 2'h0, 16'd1800, 16'd300, 5'h10, 0);
        send(1, 0, 8'h0b, 2'h0, 16'd1800, 16'd300, 5'h10, 0);
        for (i = 0; i < 5; i++) send(0, 0, 8'h0b, 2'h0, 16'd1800, 16'd300, 5'h10, 0);
        send(0, 0, 8'h0b, 2'h0, 16'd1800, 16'd300, 5'h0b, 1);
        // Deadline: 63 frames still fine; after the 64th a fragment is refused with its unit,
        // and the other expired unit is swept on its own one cycle later.
        send(1, 0, 8'h14, 2'h0, 16'd800, 16'd400, 5'h10, 0);
        send(1, 0, 8'h15, 2'h0, 16'd800, 16'd400, 5'h10, 0);
        repeat (63) frame();
        send(0, 0, 8'h14, 2'h0, 16'd800, 16'd200, 5'h10, 0);
        @(posedge clk);
        tick <= 1'b1;
        send(0, 0, 8'h15, 2'h0, 16'd800, 16'd200, 5'h0c, 1);
        @(posedge clk);
        #1;
        i = 0;
        while (ab !== 1'b1 && i < 4) begin
            @(posedge clk);
            #1;
            i++;
        end
        chk_val({ab, 7'h0, ab_tag}, 16'h8014);
        send(0, 1, 8'h14, 2'h0, 16'd800, 16'd200, 5'h0e, 0);
        // High-efficiency mode: fragments refused, an open unit abandoned.
        send(1, 0, 8'h1f, 2'h2, 16'd800, 16'd400, 5'h10, 0);
        @(posedge clk);
        high_efficiency_physical_mode <= 1'b1;
        send(1, 0, 8'h1e, 2'h2, 16'd800, 16'd400, 5'h0d, 0);
        send(0, 1, 8'h1f, 2'h2, 16'd800, 16'd400, 5'h0d, 1);
        send(1, 1, 8'h1e, 2'h2, 16'd800, 16'd800, 5'h10, 0);
        @(posedge clk);
        high_efficiency_physical_mode <= 1'b0;
        // Random complete packets around the size limit.
        for (i = 0; i < 40; i++) begin
            rp = 16'd1700 + 16'($urandom_range(200));
            rk = 16'd1 + 16'($urandom_range(1850));
            @(posedge clk);
            lbl <= 48'({$urandom, $urandom});
            send(1, 1, 8'($urandom), 2'($urandom), rp, rk, exp_whole(rp, rk), 0);
        end
        @(posedge clk);
        #1;
        chk_val(m_pass, 16'(exp_pass));
        chk_val(m_bytes, 16'(exp_bytes));
        chk_val(m_ab, 16'h4);
        print_verdict();
    end
endmodule : lite_encapsulation_limits_tb_top
